/* File: hw/lps_pkg.sv */
// constants and types shared by both ends of the linear photodiode scan link
// assumes a single 40 MHz system clock on both ends
package lps_pkg;

  // ----------------------------------------------------------------
  // array geometry and scan sequence
  // ----------------------------------------------------------------
  localparam int PIX_W         = 8;
  localparam int NUM_VAL       = 132;
  localparam int NUM_CLK       = 133;
  localparam int RST_END_PULSE = 18;
  localparam int CNT_W         = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int SCK_HZ        = 500_000;
  localparam int SCK_MIN_HZ    = 64_000;
  localparam int SCK_MAX_HZ    = 1_024_000;
  localparam int SCK_HALF_CYC  = CLK_HZ / (2 * SCK_HZ);
  localparam int GAP_NS        = 10_000;
  localparam int GAP_CYC       = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int INT_MIN_NS    = 125_000;
  localparam int INT_MIN_CYC   = (INT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INT_MAX_NS    = 100_000_000;
  localparam int DIV_W         = 8;
  localparam int TMR_W         = 24;

  // ----------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH    = 8;
  localparam int FIFO_W        = PIX_W + 1;

  typedef logic [CNT_W-1:0] lps_cnt_t;
  typedef logic [PIX_W-1:0] lps_pix_t;

  typedef enum logic [2:0] {
    LPS_IDLE,
    LPS_ARM,
    LPS_START,
    LPS_RUN,
    LPS_GAP
  } lps_state_e;

endpackage

/* File: hw/lps_if.sv */
// link between scan controller and photodiode array readout
// assumes both ends sit on the same clk; no clocking block here
`timescale 1ns/1ps
`default_nettype none
interface lps_if;
  import lps_pkg::*;
  logic     scan_start;
  logic     sensor_clk;
  lps_pix_t pix_val;
  logic     pix_oe;

  modport dev (
    input  scan_start,
    input  sensor_clk,
    output pix_val,
    output pix_oe
  );
  modport ctl (
    output scan_start,
    output sensor_clk,
    input  pix_val,
    input  pix_oe
  );
endinterface
`default_nettype wire

/* File: hw/lps_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module lps_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready  = (count_r != (AW+1)'(D));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/lps_dev.sv */
// readout logic of the photodiode array: start capture, reset window, pixel shift-out
// assumes scan_start and sensor_clk arrive as pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - start sampled high on clock edge begins scan
// - start freezes all 132 sampling capacitors together
// - integrators held reset until pulse 18 falls
// - controller spaces starts for minimum integration time
// - controller drops start before next rising edge
// - controller clock between 64 and 1024 kHz; lps_ctl runs it at 500 kHz, but a full fifo holds it high with no limit
// - controller keeps integration 0.125 to 100 ms; lps_ctl enforces only the minimum, INT_MAX_NS is unused
// - first scan after power-up is invalid
// - initialised after start plus 133 clocks
// - sequence: unconnected, dummy, 128 pixels, dummy, dark
// - values leave in shift order, 132 total
// - scan takes 133 pulses, last re-initialises
// - controller waits 10 us after pulse 133
// - output released after all 132 values
module lps_dev
  import lps_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  lps_if.dev            lnk,
  input  wire logic     wr_en,
  input  wire lps_cnt_t wr_idx,
  input  wire lps_pix_t wr_val,
  output logic          caps_frozen,
  output logic          integ_reset,
  output logic          scan_active,
  output logic          init_done,
  output logic          scan_valid
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ck_s1_r;
  logic ck_s2_r;
  logic ck_s3_r;
  logic si_s1_r;
  logic si_s2_r;
  logic rise;
  logic fall;
  logic start;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end else begin
      ck_s1_r <= lnk.sensor_clk;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      si_s1_r <= lnk.scan_start;
      si_s2_r <= si_s1_r;
    end
  end

  // both paths have equal delay, so si_s2 lines up with the clock edge
  assign rise  = ck_s2_r && !ck_s3_r;
  assign fall  = !ck_s2_r && ck_s3_r;
  assign start = rise && si_s2_r;

  // ----------------------------------------------------------------
  // pixel values: live integrators and frozen sample capacitors
  // ----------------------------------------------------------------
  lps_pix_t live_r [NUM_VAL];
  lps_pix_t hold_r [NUM_VAL];

  generate
    for (genvar i = 0; i < NUM_VAL; i++) begin : g_pix
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          live_r[i] <= '0;
          hold_r[i] <= '0;
        end else begin
          if (wr_en && wr_idx == CNT_W'(i)) begin
            live_r[i] <= wr_val;
          end
          if (start) begin
            hold_r[i] <= live_r[i];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // scan sequencing
  // ----------------------------------------------------------------
  lps_cnt_t cnt_r;
  logic     last_pulse;

  assign last_pulse = rise && scan_active && (cnt_r == CNT_W'(NUM_CLK - 1));

  // a start during a running scan restarts it; the controller is expected not to do that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= '0;
      scan_active <= 1'b0;
    end else if (start) begin
      cnt_r       <= CNT_W'(1);
      scan_active <= 1'b1;
    end else if (last_pulse) begin
      cnt_r       <= '0;
      scan_active <= 1'b0;
    end else if (rise && scan_active) begin
      cnt_r       <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      caps_frozen <= 1'b0;
    end else begin
      caps_frozen <= start;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_reset <= 1'b0;
    end else if (start) begin
      integ_reset <= 1'b1;
    end else if (fall && scan_active && cnt_r == CNT_W'(RST_END_PULSE)) begin
      integ_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // initialisation tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done <= 1'b0;
    end else if (last_pulse) begin
      init_done <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_valid <= 1'b0;
    end else if (start) begin
      scan_valid <= init_done;
    end else if (last_pulse) begin
      scan_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pixel output
  // ----------------------------------------------------------------
  lps_pix_t pix_r;
  logic     oe_r;

  assign lnk.pix_val = pix_r;
  assign lnk.pix_oe  = oe_r;

  // index 0 unconnected, 1 dummy, 2..129 active, 130 dummy, 131 dark reference
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_r <= '0;
      oe_r  <= 1'b0;
    end else if (start) begin
      // index 0 is frozen at this very edge, so it is taken from the live side
      pix_r <= init_done ? live_r[0] : '0;
      oe_r  <= 1'b1;
    end else if (last_pulse) begin
      pix_r <= '0;
      oe_r  <= 1'b0;
    end else if (rise && scan_active) begin
      pix_r <= scan_valid ? hold_r[cnt_r] : '0;
    end
  end

endmodule
`default_nettype wire

/* File: hw/lps_ctl.sv */
// scan controller: makes the sensor clock, issues starts, collects pixels into a fifo
// assumes the array end runs on the same clk; pixel pins are read without synchroniser
`timescale 1ns/1ps
`default_nettype none
module lps_ctl
  import lps_pkg::*;
#(
  parameter int INT_MIN = INT_MIN_CYC
) (
  input  wire logic     clk,
  input  wire logic     rst_n,
  lps_if.ctl            lnk,
  input  wire logic     scan_req,
  output logic          busy,
  output logic          ready_init,
  output logic          out_valid,
  input  wire logic     out_ready,
  output lps_pix_t      out_pix,
  output logic          out_last
);

  // ----------------------------------------------------------------
  // sensor clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_r;
  logic             sck_r;
  logic             tick;
  logic             do_rise;
  logic             do_fall;
  logic             samp_now;
  logic             stall;
  logic             fifo_rdy;

  assign tick    = (div_r == DIV_W'(SCK_HALF_CYC - 1));
  // a full fifo holds the clock high; this can slow the clock below its 64 kHz floor
  assign stall   = samp_now && !fifo_rdy;
  assign do_rise = tick && !sck_r;
  assign do_fall = tick && sck_r && !stall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      sck_r <= 1'b0;
    end else if (tick && !(sck_r && stall)) begin
      div_r <= '0;
      sck_r <= !sck_r;
    end else if (!tick) begin
      div_r <= div_r + 1'b1;
    end
  end

  assign lnk.sensor_clk = sck_r;

  // ----------------------------------------------------------------
  // scan state machine
  // ----------------------------------------------------------------
  lps_state_e       st_r;
  lps_cnt_t         pcnt_r;
  logic             si_r;
  logic             init_r;
  logic             pend_r;
  logic [TMR_W-1:0] gap_r;
  logic [TMR_W-1:0] int_r;
  logic             may_start;

  assign may_start = (gap_r >= TMR_W'(GAP_CYC)) && (int_r >= TMR_W'(INT_MIN));
  assign samp_now  = init_r && (st_r == LPS_START || st_r == LPS_RUN)
                     && pcnt_r != '0 && pcnt_r <= CNT_W'(NUM_VAL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= LPS_IDLE;
      si_r   <= 1'b0;
      pcnt_r <= '0;
    end else begin
      unique case (st_r)
        LPS_IDLE: begin
          if (pend_r && may_start) begin
            st_r <= LPS_ARM;
          end
        end
        LPS_ARM: begin
          if (do_fall) begin
            si_r   <= 1'b1;
            pcnt_r <= '0;
            st_r   <= LPS_START;
          end
        end
        LPS_START: begin
          if (do_rise) begin
            pcnt_r <= CNT_W'(1);
          end else if (do_fall) begin
            si_r <= 1'b0;
            st_r <= LPS_RUN;
          end
        end
        LPS_RUN: begin
          if (do_rise) begin
            pcnt_r <= pcnt_r + 1'b1;
          end else if (do_fall && pcnt_r == CNT_W'(NUM_CLK)) begin
            st_r <= LPS_GAP;
          end
        end
        LPS_GAP: begin
          st_r <= LPS_IDLE;
        end
      endcase
    end
  end

  assign lnk.scan_start = si_r;

  // gap timer runs from the fall of pulse 133, integration timer from the fall of pulse 18
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= {TMR_W{1'b1}};
      int_r <= {TMR_W{1'b1}};
    end else begin
      if (st_r == LPS_GAP) begin
        gap_r <= '0;
      end else if (gap_r != {TMR_W{1'b1}}) begin
        gap_r <= gap_r + 1'b1;
      end
      if (do_fall && st_r == LPS_RUN && pcnt_r == CNT_W'(RST_END_PULSE)) begin
        int_r <= '0;
      end else if (int_r != {TMR_W{1'b1}}) begin
        int_r <= int_r + 1'b1;
      end
    end
  end

  // the init scan leaves the request pending, so the real scan follows by itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (scan_req) begin
      pend_r <= 1'b1;
    end else if (st_r == LPS_ARM && do_fall && init_r) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r <= 1'b0;
    end else if (st_r == LPS_GAP) begin
      init_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      ready_init <= 1'b0;
    end else begin
      busy       <= (st_r != LPS_IDLE) || pend_r;
      ready_init <= init_r;
    end
  end

  // ----------------------------------------------------------------
  // pixel capture into the fifo at each falling edge
  // ----------------------------------------------------------------
  logic [FIFO_W-1:0] fifo_in;
  logic [FIFO_W-1:0] fifo_out;
  logic              push;

  assign push    = samp_now && tick && sck_r && lnk.pix_oe;
  assign fifo_in = {pcnt_r == CNT_W'(NUM_VAL), lnk.pix_val};

  lps_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_pix  = fifo_out[PIX_W-1:0];
  assign out_last = fifo_out[PIX_W];

endmodule
`default_nettype wire

/* File: verif/lps_sva.sv */
// checker for the scan link between the controller and the array end
// assumes one clk for both ends; instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module lps_sva
  import lps_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst_n,
  input wire logic     scan_start,
  input wire logic     sensor_clk,
  input wire lps_pix_t pix_val,
  input wire logic     pix_oe,
  input wire logic     caps_frozen,
  input wire logic     integ_reset,
  input wire logic     init_done,
  input wire logic     scan_valid
);
  // ----------------------------------------------------------------
  // pulse and gap counters
  // ----------------------------------------------------------------
  logic        sck_r;
  logic [7:0]  pcnt_r;
  logic [15:0] gap_r;
  logic        rise;
  logic        start;

  assign rise  = sensor_clk & ~sck_r;
  assign start = rise & scan_start;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_r <= 1'b0;
    end else begin
      sck_r <= sensor_clk;
    end
  end

  // saturates so a free running clock between scans never wraps to a false count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_r <= 8'h00;
    end else if (start) begin
      pcnt_r <= 8'h01;
    end else if (rise && pcnt_r != 8'h00 && pcnt_r < 8'hc8) begin
      pcnt_r <= pcnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 16'hffff;
    end else if (!sensor_clk && sck_r && pcnt_r == 8'h85) begin
      gap_r <= 16'h0000;
    end else if (gap_r != 16'hffff) begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_freeze;
    ##3 (caps_frozen && integ_reset && pix_oe) ##1 !caps_frozen;
  endsequence

  a_start_freeze: assert property (start |-> s_freeze)
    else $error("start did not freeze capacitors");
  a_reset_end: assert property ($fell(integ_reset) |->
    pcnt_r == 8'h12 && !$past(sensor_clk, 3) && $past(sensor_clk, 4))
    else $error("integrator reset ended off pulse 18 fall");
  a_reset_hold: assert property (rise && pcnt_r >= 8'h01 && pcnt_r <= 8'h11 |-> integ_reset)
    else $error("integrator reset dropped early");
  a_oe_release: assert property ($fell(pix_oe) |-> pcnt_r == 8'h85)
    else $error("output released off pulse 133");
  a_oe_hold: assert property (rise && pcnt_r >= 8'h01 && pcnt_r <= 8'h84 |-> pix_oe)
    else $error("output released mid scan");
  a_pix_step: assert property (pix_oe && $past(pix_oe) && $changed(pix_val) |->
    $past(sensor_clk, 3) && !$past(sensor_clk, 4))
    else $error("pixel changed off a clock rise");
  a_start_low: assert property (rise && pcnt_r >= 8'h01 && pcnt_r <= 8'h84 |-> !scan_start)
    else $error("start high during readout");
  a_start_gap: assert property (start |-> int'(gap_r) >= GAP_CYC - 2)
    else $error("start too soon after pulse 133");
  a_init_set: assert property ($rose(init_done) |-> pcnt_r == 8'h85 ##1 init_done)
    else $error("init flag set off pulse 133");
  a_valid_gate: assert property ($rose(scan_valid) |-> init_done && caps_frozen)
    else $error("valid scan before init");
endmodule
`default_nettype wire

/* File: verif/lps_bench.sv */
// self-checking bench: controller and array end joined over the link
// assumes a 40 MHz clk; INT_MIN shortened to 10 cycles to keep the run short
`timescale 1ns/1ps
`default_nettype none
module lps_bench;
  import lps_pkg::*;
  typedef struct packed {lps_cnt_t idx; lps_pix_t val; logic last;} lps_row_s;
  localparam int DLY = 2;
  logic     clk, rst_n, scan_req, out_ready, wr_en, out_last;
  logic     busy, ready_init, out_valid, caps_frozen, integ_reset;
  logic     scan_active, init_done, scan_valid;
  lps_cnt_t wr_idx;
  lps_pix_t wr_val, out_pix;
  lps_pix_t got [NUM_VAL+1];
  logic     lst [NUM_VAL+1];
  int       n_got, failures, n_compared;
  // boundaries of the sequence plus two mid pixels: unconnected, dummies, first/last pixel, dark
  lps_row_s rows [8] = '{'{8'h00, 8'h11, 1'b0}, '{8'h01, 8'h22, 1'b0},
    '{8'h02, 8'h33, 1'b0}, '{8'h40, 8'hff, 1'b0}, '{8'h41, 8'h5a, 1'b0},
    '{8'h81, 8'ha5, 1'b0}, '{8'h82, 8'hc3, 1'b0}, '{8'h83, 8'h7e, 1'b1}};

  lps_if lnk ();
  lps_dev u_lps_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_val(wr_val), .caps_frozen(caps_frozen), .integ_reset(integ_reset),
    .scan_active(scan_active), .init_done(init_done), .scan_valid(scan_valid));
  lps_ctl #(.INT_MIN(10)) u_lps_ctl (.clk(clk), .rst_n(rst_n), .lnk(lnk),
    .scan_req(scan_req), .busy(busy), .ready_init(ready_init), .out_valid(out_valid),
    .out_ready(out_ready), .out_pix(out_pix), .out_last(out_last));
  lps_sva u_lps_sva (.clk(clk), .rst_n(rst_n), .scan_start(lnk.scan_start),
    .sensor_clk(lnk.sensor_clk), .pix_val(lnk.pix_val), .pix_oe(lnk.pix_oe),
    .caps_frozen(caps_frozen), .integ_reset(integ_reset), .init_done(init_done),
    .scan_valid(scan_valid));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_v(string what, logic [8:0] exp, logic [8:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_b(string what, logic exp, logic seen);
    chk_v(what, {8'h00, exp}, {8'h00, seen});
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask
  task automatic load();
    foreach (rows[i]) begin
      wr_en  = 1'b1;
      wr_idx = rows[i].idx;
      wr_val = rows[i].val;
      tick(1);
    end
    wr_en = 1'b0;
  endtask
  task automatic request();
    scan_req = 1'b1;
    tick(1);
    scan_req = 1'b0;
  endtask
  // reads on the falling edge so the word is taken by the following rising edge
  task automatic collect();
    int guard;
    n_got = 0;
    guard = 0;
    while (guard < 60000 && (n_got == 0 || lst[n_got-1] !== 1'b1) && n_got <= NUM_VAL) begin
      @(negedge clk);
      guard++;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        got[n_got] = out_pix;
        lst[n_got] = out_last;
        n_got++;
      end
    end
    tick(1);
  endtask
  task automatic check_scan();
    chk_v("word count", 9'(NUM_VAL), 9'(n_got));
    foreach (rows[i]) begin
      chk_v("pixel", {1'b0, rows[i].val}, {1'b0, got[rows[i].idx]});
      chk_b("last flag", rows[i].last, lst[rows[i].idx]);
    end
  endtask
  task automatic chk_idle();
    chk_b("output enable", 1'b0, lnk.pix_oe);
    chk_b("init flag", 1'b0, init_done);
    chk_b("init ready", 1'b0, ready_init);
    chk_b("start line", 1'b0, lnk.scan_start);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(90000 * 25);
    failures++;
    end_sim();
  end
  initial begin
    rst_n     = 1'b0;
    scan_req  = 1'b0;
    out_ready = 1'b0;
    wr_en     = 1'b0;
    wr_idx    = 8'h00;
    wr_val    = 8'h00;
    tick(3);
    rst_n = 1'b1;
    chk_idle();
    tick(1);
    load();
    out_ready = 1'b1;
    request();
    tick(1);
    chk_b("busy", 1'b1, busy);
    collect();
    check_scan();
    chk_b("init flag", 1'b1, init_done);
    chk_b("init ready", 1'b1, ready_init);
    // stalled reader: fifo fills and the sensor clock is stretched high
    out_ready = 1'b0;
    request();
    tick(8000);
    chk_b("fifo valid", 1'b1, out_valid);
    chk_b("clock held", 1'b1, lnk.sensor_clk);
    chk_b("scan active", 1'b1, scan_active);
    chk_b("scan valid", 1'b1, scan_valid);
    tick(200);
    chk_b("clock held", 1'b1, lnk.sensor_clk);
    out_ready = 1'b1;
    collect();
    check_scan();
    // reset in mid scan: next scan is an init pass again
    request();
    tick(3000);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    chk_idle();
    tick(1);
    load();
    request();
    collect();
    check_scan();
    tick(600);
    end_sim();
  end
endmodule
`default_nettype wire
